// *** dps_pkg.sv ***
package dps_pkg;

  // ==========================================================================
  // clock and link timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;

  // times in ns, as printed for the port
  localparam int WRITE_PULSE_WIDTH_NS       = 40;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 30;
  localparam int WRITE_TO_OUTPUT_FLOAT_NS   = 25;
  localparam int SELECT_TO_WRITE_END_NS     = 45;
  localparam int READ_ACCESS_NS             = 55;
  localparam int TOKEN_WRITE_TO_READ_NS     = 10;
  localparam int TOKEN_UPDATE_PULSE_NS      = 15;
  localparam int WRITE_HIGH_AFTER_BUSY_NS   = 35;

  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int t_ns);
    int c;
    c = t_ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int PWE_CYC  = cyc_min(WRITE_PULSE_WIDTH_NS);
  localparam int SD_CYC   = cyc_min(DATA_SETUP_TO_WRITE_END_NS);
  localparam int HZWE_CYC = cyc_min(WRITE_TO_OUTPUT_FLOAT_NS); // a maximum: round up
  localparam int SCE_CYC  = cyc_min(SELECT_TO_WRITE_END_NS);
  localparam int ACC_CYC  = cyc_max(READ_ACCESS_NS);
  localparam int SWRD_CYC = cyc_min(TOKEN_WRITE_TO_READ_NS);
  localparam int SOP_CYC  = cyc_min(TOKEN_UPDATE_PULSE_NS);
  localparam int WH_CYC   = cyc_min(WRITE_HIGH_AFTER_BUSY_NS);
  localparam int SYNC_CYC = 2;

  // derived sequence lengths
  localparam int WR_CYC    = imax(PWE_CYC, SCE_CYC);
  localparam int WR_OE_CYC = imax(WR_CYC, HZWE_CYC + SD_CYC);
  localparam int RD_CYC    = ACC_CYC + SYNC_CYC + 1;
  localparam int GAP_CYC   = imax(SWRD_CYC, SOP_CYC);

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ADDR     = 8'h04;
  localparam logic [7:0] OFS_WDATA    = 8'h08;
  localparam logic [7:0] OFS_RDATA    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // control fields
  localparam int CTL_START    = 0;
  localparam int CTL_WRITE    = 1;
  localparam int CTL_TOKEN    = 2;
  localparam int CTL_UPPER    = 3;
  localparam int CTL_LOWER    = 4;
  localparam int CTL_READBACK = 5;
  localparam int CTL_PRIMARY  = 8;
  localparam int CTL_OE_WRITE = 9;

  // status fields
  localparam int STS_ACTIVE = 0;
  localparam int STS_BUSY_N = 1;
  localparam int STS_INT_N  = 2;

  // interrupt fields
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_BUSY     = 1;
  localparam int IRQ_MAILBOX  = 2;
  localparam int IRQ_W        = 3;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [31:0]      CTRL_RST     = 32'h0000_0118;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic write;
    logic token;
    logic upper;
    logic lower;
    logic readback;
    logic primary;
    logic oe_write;
  } dps_op_t;

  typedef struct packed {
    logic ce_n;
    logic tok_n;
    logic rw;
    logic oe_n;
    logic upper_n;
    logic lower_n;
  } dps_pins_t;

  localparam dps_pins_t PINS_IDLE = '{ce_n: 1'b1, tok_n: 1'b1, rw: 1'b1,
                                      oe_n: 1'b1, upper_n: 1'b1, lower_n: 1'b1};

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// *** dps_sync.sv ***
`timescale 1ns/100ps

// ============================================================================
// two-flop synchroniser for pin inputs
// ============================================================================
module dps_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // pin side and clock side
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// *** dps_host.sv ***
// Contract
// - keep the direction pin at read for the whole of every read
// - address-only continuous reads are for the array, never for tokens
// - address is valid no later than port select falls in a read
// - array: select low, a lane low, token select high; token: select high
// - direction pin stays at read whenever the address changes
// - a write ends at the first of select rising or direction to read
// - with output enable low, stretch the write pulse by float plus setup; the code makes it the larger of the write pulse and float plus setup
// - upper and lower byte each reached through its own lane strobe
// - do not drive data while the device still drives the data pins
// - port select stays high through token write and its read-back
// - primary mode: busy is a device output; secondary: it stalls writes
// - the chosen target stays valid until the write ends
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps

module dps_host
  import dps_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  output logic [31:0]            HRDATA,
  // interrupt
  output logic                   IRQ,
  // memory port control
  output logic [ADDR_W-1:0]      SRAM_ADDR,
  output logic                   SRAM_CE_N,
  output logic                   SRAM_RW,
  output logic                   SRAM_OE_N,
  output logic                   UPPER_LANE_STROBE_N,
  output logic                   LOWER_LANE_STROBE_N,
  output logic                   TOKEN_LATCH_SELECT_N,
  output logic                   PRIMARY_SEL,
  // memory port data
  input  wire logic [15:0]       DQ_IN,
  output logic [15:0]            DQ_OUT,
  output logic                   DQ_OE,
  // memory port flags
  input  wire logic              BUSY_N_IN,
  input  wire logic              MAILBOX_N_IN
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (ADDR_W < 1 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie between 1 and 32");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WSTROBE, ST_WEND, ST_GAP, ST_RSTROBE, ST_REND
  } dps_state_t;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [15:0] dq_s;
  logic [1:0]  flag_s;
  logic        busy_n_s;
  logic        mbox_n_s;

  dps_sync #(.W(16), .RST_VAL(16'h0000)) u_sync_dq (
    .clk  (CLK),
    .rstn (RSTN),
    .d    (DQ_IN),
    .q    (dq_s)
  );

  dps_sync #(.W(2), .RST_VAL(2'h3)) u_sync_flag (
    .clk  (CLK),
    .rstn (RSTN),
    .d    ({BUSY_N_IN, MAILBOX_N_IN}),
    .q    (flag_s)
  );

  assign busy_n_s = flag_s[1];
  assign mbox_n_s = flag_s[0];

  // ==========================================================================
  // ahb-lite address and data phase
  // ==========================================================================
  logic        ap_wr_r;
  logic [7:0]  ap_ofs_r;
  logic        ap_take;
  logic        dp_wr;

  // only the low byte is decoded; the map aliases above it
  assign ap_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3);
  assign dp_wr   = ap_wr_r;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ap_wr_r  <= 1'b0;
      ap_ofs_r <= 8'h00;
    end
    else if (HREADY)
    begin
      ap_wr_r  <= ap_take && HWRITE;
      ap_ofs_r <= {HADDR[7:2], 2'b00};
    end
  end

  // zero wait state, always okay
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ==========================================================================
  // software registers
  // ==========================================================================
  logic [31:0]       ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [15:0]       wdata_r;
  logic [15:0]       rdata_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_stat_nxt;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_evt;
  dps_state_t        state_r;
  logic              start;

  // start only from idle; a start during a cycle is dropped
  assign start = dp_wr && ap_ofs_r == OFS_CTRL && HWDATA[CTL_START] && state_r == ST_IDLE;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_r     <= CTRL_RST;
      addr_r     <= '0;
      wdata_r    <= 16'h0000;
      irq_mask_r <= IRQ_MASK_RST;
    end
    else if (dp_wr)
    begin
      case (ap_ofs_r)
        OFS_CTRL:     ctrl_r     <= {HWDATA[31:1], 1'b0};
        OFS_ADDR:     addr_r     <= HWDATA[ADDR_W-1:0];
        OFS_WDATA:    wdata_r    <= HWDATA[15:0];
        OFS_IRQ_MASK: irq_mask_r <= HWDATA[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // sticky status, write one to clear, set beats clear
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (dp_wr && ap_ofs_r == OFS_IRQ_STAT)
      irq_stat_nxt = irq_stat_r & ~HWDATA[IRQ_W-1:0];
    irq_stat_nxt = irq_stat_nxt | irq_evt;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_stat_r <= '0;
      IRQ        <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      IRQ        <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // read data registered in the address phase; a write in the data phase
  // just before is not yet visible to a read issued back to back
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      HRDATA <= 32'h0000_0000;
    else if (ap_take && !HWRITE)
    begin
      case ({HADDR[7:2], 2'b00})
        OFS_CTRL:     HRDATA <= ctrl_r;
        OFS_ADDR:     HRDATA <= 32'(addr_r);
        OFS_WDATA:    HRDATA <= {16'h0000, wdata_r};
        OFS_RDATA:    HRDATA <= {16'h0000, rdata_r};
        OFS_STATUS:   HRDATA <= {29'h0, mbox_n_s, busy_n_s, state_r != ST_IDLE};
        OFS_IRQ_STAT: HRDATA <= {29'h0, irq_stat_r};
        OFS_IRQ_MASK: HRDATA <= {29'h0, irq_mask_r};
        default:      HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // port sequencer
  // ==========================================================================
  dps_op_t   op_r;
  dps_pins_t pins_r;
  logic [7:0] cnt_r;
  logic [7:0] wlen_r;
  logic       mbox_prev_r;
  logic       busy_evt;
  logic       done_evt;
  logic       sel_low_ce;

  // array cycles use port select, token cycles the token select only
  assign sel_low_ce = !op_r.token;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r   <= ST_IDLE;
      op_r      <= '0;
      pins_r    <= PINS_IDLE;
      cnt_r     <= 8'h00;
      wlen_r    <= 8'h00;
      SRAM_ADDR <= '0;
      DQ_OUT    <= 16'h0000;
      DQ_OE     <= 1'b0;
      rdata_r   <= 16'h0000;
      busy_evt  <= 1'b0;
      done_evt  <= 1'b0;
    end
    else
    begin
      busy_evt <= 1'b0;
      done_evt <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          pins_r <= PINS_IDLE;
          DQ_OE  <= 1'b0;
          if (start)
          begin
            // address moves only while direction is at read
            op_r      <= '{write: HWDATA[CTL_WRITE], token: HWDATA[CTL_TOKEN],
                           upper: HWDATA[CTL_UPPER], lower: HWDATA[CTL_LOWER],
                           readback: HWDATA[CTL_READBACK],
                           primary: HWDATA[CTL_PRIMARY], oe_write: HWDATA[CTL_OE_WRITE]};
            SRAM_ADDR <= addr_r;
            DQ_OUT    <= wdata_r;
            wlen_r    <= HWDATA[CTL_OE_WRITE] ? 8'(WR_OE_CYC) : 8'(WR_CYC);
            cnt_r     <= 8'h00;
            state_r   <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          cnt_r <= 8'h00;
          if (op_r.write)
          begin
            // select, lanes and direction fall together: device output floats
            pins_r.ce_n    <= !sel_low_ce;
            pins_r.tok_n   <= sel_low_ce;
            pins_r.rw      <= 1'b0;
            pins_r.upper_n <= !op_r.upper;
            pins_r.lower_n <= !op_r.lower;
            pins_r.oe_n    <= !op_r.oe_write;
            DQ_OE          <= !op_r.oe_write;
            state_r        <= ST_WSTROBE;
          end
          else
          begin
            state_r <= ST_RSTROBE;
            pins_r  <= '{ce_n: !sel_low_ce, tok_n: sel_low_ce, rw: 1'b1, oe_n: 1'b0,
                         upper_n: !op_r.upper, lower_n: !op_r.lower};
          end
        end
        ST_WSTROBE:
        begin
          cnt_r <= cnt_r + 8'h01;
          // with output enable low, drive only after the device floats
          if (op_r.oe_write && cnt_r + 8'h01 >= 8'(HZWE_CYC))
            DQ_OE <= 1'b1;
          if (!op_r.primary && !busy_n_s)
          begin
            // secondary mode: busy holds the pulse, then a recovery span
            cnt_r    <= 8'h00;
            busy_evt <= 1'b1;
            if (wlen_r < 8'(WH_CYC))
              wlen_r <= 8'(WH_CYC);
          end
          else if (cnt_r + 8'h01 >= wlen_r)
          begin
            // end of write: direction and select rise on the same edge
            pins_r  <= PINS_IDLE;
            state_r <= ST_WEND;
          end
        end
        ST_WEND:
        begin
          // data held one cycle past the end, address held too
          DQ_OE <= 1'b0;
          cnt_r <= 8'h00;
          if (op_r.token && op_r.readback)
            state_r <= ST_GAP;
          else
          begin
            done_evt <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        ST_GAP:
        begin
          // token select high for the update pulse, port select stays high
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r + 8'h01 >= 8'(GAP_CYC))
          begin
            op_r.write <= 1'b0;
            cnt_r      <= 8'h00;
            pins_r     <= '{ce_n: 1'b1, tok_n: 1'b0, rw: 1'b1, oe_n: 1'b0,
                            upper_n: !op_r.upper, lower_n: !op_r.lower};
            state_r    <= ST_RSTROBE;
          end
        end
        ST_RSTROBE:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r + 8'h01 >= 8'(RD_CYC))
          begin
            // sample after access time plus synchroniser latency
            rdata_r  <= dq_s;
            busy_evt <= op_r.primary && !busy_n_s && !op_r.token;
            pins_r   <= PINS_IDLE;
            state_r  <= ST_REND;
          end
        end
        ST_REND:
        begin
          done_evt <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default:
        begin
          pins_r  <= PINS_IDLE;
          DQ_OE   <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // flag events and pin outputs
  // ==========================================================================
  // mailbox flag falls some time after the far side's last enable; we only
  // see the level, so a falling edge of the synced flag is the event
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      mbox_prev_r <= 1'b1;
    else
      mbox_prev_r <= mbox_n_s;
  end

  assign irq_evt = {mbox_prev_r && !mbox_n_s, busy_evt, done_evt};

  // token ownership is read back in bit zero; losing a contended request
  // shows as a one there, software retries
  assign SRAM_CE_N            = pins_r.ce_n;
  assign SRAM_RW              = pins_r.rw;
  assign SRAM_OE_N            = pins_r.oe_n;
  assign UPPER_LANE_STROBE_N  = pins_r.upper_n;
  assign LOWER_LANE_STROBE_N  = pins_r.lower_n;
  assign TOKEN_LATCH_SELECT_N = pins_r.tok_n;

  // primary strap follows the control register
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      PRIMARY_SEL <= 1'b1;
    else
      PRIMARY_SEL <= ctrl_r[CTL_PRIMARY];
  end

  // the address-only read style is never used: every read strobes port select or, for tokens, token select

endmodule

// *** dps_host_props.sv ***
`timescale 1ns/100ps
// ============================================================================
// port protocol checker
// ============================================================================
module dps_host_props
  import dps_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RSTN,
  // memory port
  input wire logic [ADDR_W-1:0] SRAM_ADDR,
  input wire logic              SRAM_CE_N,
  input wire logic              SRAM_RW,
  input wire logic              SRAM_OE_N,
  input wire logic              UPPER_LANE_STROBE_N,
  input wire logic              LOWER_LANE_STROBE_N,
  input wire logic              TOKEN_LATCH_SELECT_N,
  input wire logic              DQ_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // either target selected
  wire sel_any = !SRAM_CE_N || !TOKEN_LATCH_SELECT_N;

  // ==========================================================================
  // cycle steps
  // ==========================================================================
  sequence wr_go;  $fell(SRAM_RW); endsequence
  sequence wr_end; $rose(SRAM_RW); endsequence
  sequence rd_go;  $fell(SRAM_OE_N) && SRAM_RW; endsequence

  addr_at_read_a: assert property ($changed(SRAM_ADDR) |-> SRAM_RW)
    else $error("address moved with direction at write");
  rd_dir_held_a: assert property (rd_go |-> (SRAM_RW && $stable(SRAM_ADDR))[*8])
    else $error("read cycle lost direction or address");
  sel_excl_a: assert property (!(!SRAM_CE_N && !TOKEN_LATCH_SELECT_N))
    else $error("array and token selected together");
  lane_on_a: assert property (sel_any |-> !(UPPER_LANE_STROBE_N && LOWER_LANE_STROBE_N))
    else $error("select without a lane strobe");
  wr_hold_a: assert property (wr_go |-> sel_any ##1 ($stable(SRAM_CE_N) &&
    $stable(TOKEN_LATCH_SELECT_N) && $stable(SRAM_ADDR))[*4])
    else $error("target or address moved inside a write");
  wr_pulse_a: assert property (wr_go |-> !SRAM_RW[*5])
    else $error("write pulse too short");
  wr_data_a: assert property (wr_end |-> DQ_OE && $past(DQ_OE, 3))
    else $error("data setup or hold too short");
  float_wait_a: assert property ($rose(DQ_OE) && !SRAM_OE_N |-> !$past(SRAM_RW, 3))
    else $error("data driven before device outputs float");
  no_fight_a: assert property (!(DQ_OE && !SRAM_OE_N && SRAM_RW && sel_any))
    else $error("host drives data during a read");
  tok_gap_a: assert property ($rose(TOKEN_LATCH_SELECT_N) |-> SRAM_CE_N[*3])
    else $error("port select fell around token read-back");
endmodule

bind dps_host dps_host_props #(.ADDR_W(ADDR_W)) u_props (
  .CLK(CLK), .RSTN(RSTN), .SRAM_ADDR(SRAM_ADDR), .SRAM_CE_N(SRAM_CE_N),
  .SRAM_RW(SRAM_RW), .SRAM_OE_N(SRAM_OE_N), .UPPER_LANE_STROBE_N(UPPER_LANE_STROBE_N),
  .LOWER_LANE_STROBE_N(LOWER_LANE_STROBE_N), .TOKEN_LATCH_SELECT_N(TOKEN_LATCH_SELECT_N),
  .DQ_OE(DQ_OE)
);

// *** dps_sram_model.sv ***
`timescale 1ns/100ps
// ============================================================================
// behavioural device port, 64 words, 8 token latches
// ============================================================================
module dps_sram_model #(
  parameter int AW = 14
) (
  // port control
  input  wire logic [AW-1:0] a,
  input  wire logic          ce_n,
  input  wire logic          rw,
  input  wire logic          oe_n,
  input  wire logic          ub_n,
  input  wire logic          lb_n,
  input  wire logic          tok_n,
  // data and flags
  input  wire logic [15:0]   d,
  output wire logic [15:0]   q,
  output wire logic          busy_n,
  output wire logic          int_n,
  // far port stimulus
  input  wire logic          clash,
  input  wire logic [7:0]    other_own,
  input  wire logic          mail
);
  logic [15:0] mem [0:63];
  logic [7:0]  own_r = 8'h00;
  logic [15:0] held  = 16'h0000;
  wire         rd_d;

  // target decode
  wire arr  = !ce_n && tok_n;
  wire tsel = ce_n && !tok_n;
  wire lane = !ub_n || !lb_n;
  wire wr   = (arr || tsel) && lane && !rw && busy_n;
  wire rd   = (arr || tsel) && lane && rw && !oe_n;
  wire [15:0] rdw = arr ? mem[a[5:0]] : {15'h7FFF, !own_r[a[2:0]]};

  // flags from the far port
  assign busy_n = !(clash && arr);
  assign int_n  = !mail;

  // data appears after the access time; off the bus it shows the inverse
  assign #50 rd_d = rd;
  assign q = (rd && rd_d) ? rdw : ~held;
  always @*
    if (rd && rd_d)
      held = rdw;

  // level write: the value before the first deasserting edge sticks
  always @*
    if (wr && arr)
    begin
      if (!ub_n)
        mem[a[5:0]][15:8] = d[15:8];
      if (!lb_n)
        mem[a[5:0]][7:0] = d[7:0];
    end

  // bit zero low requests; a latch held by the far port refuses
  always @*
    if (wr && tsel)
      own_r[a[2:0]] = d[0] ? 1'b0 : !other_own[a[2:0]];
endmodule

// *** dual_port_sram_port_access_tb.sv ***
`timescale 1ns/100ps
// ============================================================================
// bench for the dual-port port controller
// ============================================================================
module dual_port_sram_port_access_tb;
  import dps_pkg::*;
  localparam logic [31:0] C_W  = 32'h1 << CTL_WRITE;
  localparam logic [31:0] C_T  = (32'h1 << CTL_TOKEN) | (32'h1 << CTL_READBACK);
  localparam logic [31:0] C_U  = 32'h1 << CTL_UPPER;
  localparam logic [31:0] C_L  = 32'h1 << CTL_LOWER;
  localparam logic [31:0] C_P  = 32'h1 << CTL_PRIMARY;
  localparam logic [31:0] C_OE = 32'h1 << CTL_OE_WRITE;

  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        clash  = 1'b0;
  logic        mail   = 1'b0;
  logic [7:0]  other  = 8'h00;
  logic [31:0] rd;
  int          fails     = 0;
  int          tests_run = 0;
  wire  [31:0] hrdata;
  wire  [13:0] sa;
  wire  [15:0] dq_out, q;
  wire         hready, hresp, irq, ce_n, rw, oe_n, ub_n, lb_n, tk_n, prim, dq_oe, busy_n, int_n;
  // host drive wins only while its enable is up
  wire  [15:0] dq = dq_oe ? dq_out : q;

  // 100 MHz
  always #5 clk = ~clk;

  dps_host dut (
    .CLK(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
    .HRDATA(hrdata), .IRQ(irq), .SRAM_ADDR(sa), .SRAM_CE_N(ce_n), .SRAM_RW(rw),
    .SRAM_OE_N(oe_n), .UPPER_LANE_STROBE_N(ub_n), .LOWER_LANE_STROBE_N(lb_n),
    .TOKEN_LATCH_SELECT_N(tk_n), .PRIMARY_SEL(prim), .DQ_IN(dq), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .BUSY_N_IN(busy_n), .MAILBOX_N_IN(int_n)
  );

  dps_sram_model u_dev (
    .a(sa), .ce_n(ce_n), .rw(rw), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .tok_n(tk_n),
    .d(dq), .q(q), .busy_n(busy_n), .int_n(int_n), .clash(clash), .other_own(other),
    .mail(mail)
  );

  // ==========================================================================
  // checking and closing
  // ==========================================================================
  task automatic final_report;
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fails++;
        final_report();
      end
      @(posedge clk);
    end
  endtask

  // one single-word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // one device cycle; the sticky done bit avoids racing the active flag
  task automatic acc(input logic [13:0] a, input logic [15:0] d, input logic [31:0] ctl);
    int n;
    ahb(1'b1, OFS_ADDR, {18'h0, a});
    ahb(1'b1, OFS_WDATA, {16'h0, d});
    ahb(1'b1, OFS_IRQ_STAT, 32'h7);
    ahb(1'b1, OFS_CTRL, ctl | 32'h1);
    n = 0;
    do
    begin
      ahb(1'b0, OFS_IRQ_STAT, 32'h0);
      n++;
      if (n > 60)
      begin
        fails++;
        final_report();
      end
    end while (rd[IRQ_DONE] !== 1'b1);
    ahb(1'b0, OFS_RDATA, 32'h0);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    chk({hresp, ce_n, tk_n, rw, ub_n, lb_n, dq_oe, prim}, 8'h7D);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RST);
    ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_array;
    acc(14'h0005, 16'hA5C3, C_P | C_W | C_U | C_L);
    acc(14'h3FFF, 16'h5A3C, C_P | C_OE | C_W | C_U | C_L);
    acc(14'h0005, 16'h1234, C_P | C_OE | C_W | C_U);
    acc(14'h0005, 16'h0000, C_P | C_U | C_L);
    chk(rd, 32'h0000_12C3);
    acc(14'h3FFF, 16'h0000, C_P | C_L);
    chk(rd, 32'h0000_5A3C);
  endtask

  task automatic t_irq;
    ahb(1'b1, OFS_IRQ_MASK, 32'h1);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({rd[IRQ_DONE], irq}, 2'h3);
    ahb(1'b1, OFS_IRQ_MASK, 32'h6);
    ahb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk({rd[30:0], irq}, {31'h6, 1'b0});
    ahb(1'b1, OFS_IRQ_STAT, 32'h1);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[IRQ_DONE], 1'b0);
  endtask

  task automatic t_token;
    other <= 8'h10;
    acc(14'h0003, 16'hFFFE, C_P | C_T | C_W | C_L);
    chk(rd[0], 1'b0);
    acc(14'h0004, 16'hFFFE, C_P | C_T | C_W | C_U);
    chk(rd[0], 1'b1);
    acc(14'h0003, 16'hFFFF, C_P | C_T | C_W | C_L);
    chk(rd[0], 1'b1);
    acc(14'h0004, 16'h0000, C_P | C_T | C_L);
    chk(rd[0], 1'b1);
  endtask

  task automatic t_busy;
    time t0;
    clash <= 1'b1;
    acc(14'h0007, 16'h0000, C_P | C_U | C_L);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[IRQ_BUSY], 1'b1);
    t0 = $time;
    fork
      acc(14'h0007, 16'h7777, C_W | C_U | C_L);
      begin
        repeat (40) @(posedge clk);
        clash <= 1'b0;
      end
    join
    // a stalled write cannot finish before the busy release
    chk(($time - t0) > 420, 1'b1);
    acc(14'h0007, 16'h0000, C_P | C_U | C_L);
    chk(rd, 32'h0000_7777);
  endtask

  task automatic t_mail;
    mail <= 1'b1;
    ahb(1'b0, OFS_STATUS, 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STS_INT_N], 1'b0);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[IRQ_MAILBOX], 1'b1);
    mail <= 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_array();
    t_irq();
    t_token();
    t_busy();
    t_mail();
    final_report();
  end
endmodule
